//--- logic/sig_input_cond.sv
// two-flop synchroniser and stable-time filter for one external input
`timescale 1ns/1ns
`default_nettype none

module sig_input_cond #(
  parameter int unsigned DEB_CYC = 1,
  parameter logic RST_LEVEL = 1'b0
) (
  input wire logic clk_in, // system clock
  input wire logic rst_in, // synchronous reset, high
  input wire logic raw_in, // raw pin level
  output logic level_out // filtered level
);

  sig_pkg::sig_cond_state_t st_ff;
  sig_pkg::sig_cond_state_t nxt_st;

  // sync chain, then accept a new level only after it stays put
  always_comb begin
    nxt_st = st_ff;
    nxt_st.s1 = raw_in;
    nxt_st.s2 = st_ff.s1;
    if (st_ff.s2 == st_ff.level) begin
      nxt_st.cnt = '0;
    end else if (st_ff.cnt >= sig_pkg::DEB_CNT_W'(DEB_CYC - 1)) begin
      nxt_st.level = st_ff.s2;
      nxt_st.cnt = '0;
    end else begin
      nxt_st.cnt = st_ff.cnt + sig_pkg::DEB_CNT_W'(1);
    end
  end

  // state register
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_ff <= '{s1: RST_LEVEL, s2: RST_LEVEL, level: RST_LEVEL, cnt: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign level_out = st_ff.level;

endmodule : sig_input_cond
`default_nettype wire

//--- logic/sig_pkg.sv
// shared constants and carrier types for the speed interlock output guard
package sig_pkg;

  // clock rate and derived cycle counts
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned DEBOUNCE_MS = 10;
  localparam int unsigned DEBOUNCE_CYC = (DEBOUNCE_MS * (CLK_HZ / 1000));
  localparam int unsigned GATE_MS = 100;
  localparam int unsigned GATE_CYC = (GATE_MS * (CLK_HZ / 1000));
  localparam int unsigned SYNC_ONLY_CYC = 1;

  // counter widths
  localparam int unsigned DEB_CNT_W = 20;
  localparam int unsigned GATE_CNT_W = 24;
  localparam int unsigned SPEED_W = 16;

  // register byte addresses
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_SPEED = 4'h8;
  localparam logic [3:0] REG_SETPOINT = 4'hc;

  // control register fields
  localparam int unsigned CTRL_INHIBIT_BIT = 0;
  localparam logic CTRL_INHIBIT_RST = 1'b0;

  // status register fields
  localparam int unsigned STAT_COIL_BIT = 0;
  localparam int unsigned STAT_IND_BIT = 1;
  localparam int unsigned STAT_MODE_LSB = 2;
  localparam int unsigned STAT_IND_FAULT_BIT = 5;
  localparam int unsigned STAT_LATCH_SEL_BIT = 6;
  localparam int unsigned STAT_MPH_SEL_BIT = 7;
  localparam int unsigned STAT_OVERSPEED_BIT = 8;

  // setpoint register fields
  localparam int unsigned SETP_ENGAGE_LSB = 0;
  localparam int unsigned SETP_DISENGAGE_LSB = 16;

  // setpoint reset values
  localparam logic [SPEED_W-1:0] ENGAGE_RST = 16'h0010;
  localparam logic [SPEED_W-1:0] DISENGAGE_RST = 16'h0020;

  // operating state of the guard
  typedef enum logic [2:0] {
    ST_OFF,
    ST_WAIT,
    ST_ON,
    ST_LOCKED,
    ST_INTERLOCK,
    ST_OVERCURRENT,
    ST_PROGRAM
  } sig_mode_t;

  // avalon-mm request from the master
  typedef struct packed {
    logic read;
    logic write;
    logic [3:0] address;
    logic [31:0] writedata;
  } sig_avs_req_t;

  // avalon-mm answer to the master
  typedef struct packed {
    logic waitrequest;
    logic [31:0] readdata;
  } sig_avs_rsp_t;

  // state of one input conditioner
  typedef struct packed {
    logic s1;
    logic s2;
    logic level;
    logic [DEB_CNT_W-1:0] cnt;
  } sig_cond_state_t;

  // state of the guard top
  typedef struct packed {
    sig_mode_t mode;
    logic coil;
    logic ind;
    logic ind_fault;
    logic inhibit;
    logic sp_idx;
    logic sp_prev;
    logic pulse_prev;
    logic [SPEED_W-1:0] pulse_cnt;
    logic [GATE_CNT_W-1:0] gate_cnt;
    logic [SPEED_W-1:0] speed;
    logic [SPEED_W-1:0] engage;
    logic [SPEED_W-1:0] disengage;
    sig_avs_rsp_t rsp;
  } sig_top_state_t;

endpackage : sig_pkg

//--- logic/sig_top.sv
// speed and interlock guard that switches activation power through to a coil
//
// Overview of operation
// - first energizing only while measured rpm is below the engage setpoint
// - coil drops when measured rpm exceeds the disengage setpoint
// - standard rpm mode re-energizes automatically once rpm falls below engage
// - latched rpm mode holds coil off until activation power goes off then on; the code also releases it through program mode
// - latched rpm re-energize also needs rpm below the engage setpoint
// - mph mode drops coil whenever vehicle speed exceeds its single setpoint
// - mph trip is always latched, restored only by an activation power cycle; the code also restores it through program mode
// - mph re-energize also needs vehicle speed below the disengage setpoint
// - grounded interlock input drops the coil
// - after interlock, coil stays off until released and speed conditions met
// - coil output switches off on coil overcurrent
// - indicator output switches off on indicator overcurrent
// - coil is powered only while activation power input is present
// - all configuration comes from grounded or open programming inputs
// - grounded program input enters program mode, release returns to normal
// - each setpoint grounding in program mode captures engage, then disengage
// - in normal mode grounded setpoint input selects latched rpm, open standard
// - overcurrent shutdown holds until activation power is cycled; the code also clears it through program mode
//
// Added by the designer: the address map and register access over Avalon-MM.
`timescale 1ns/1ns
`default_nettype none

module sig_top #(
  parameter int unsigned DEB_CYC = sig_pkg::DEBOUNCE_CYC,
  parameter int unsigned GATE_CYC = sig_pkg::GATE_CYC
) (
  input wire logic clk_in, // system clock, 100 mhz
  input wire logic rst_in, // synchronous reset, high
  input wire logic activation_power_in, // operator switch power present, high
  input wire logic safety_interlock_n_in, // low when any safety switch closed
  input wire logic program_mode_n_in, // low selects program mode
  input wire logic setpoint_latch_select_n_in, // low: setpoint tap or latch select
  input wire logic speed_source_mph_n_in, // low selects vehicle speed source
  input wire logic engine_speed_pulse_in, // tachometer pulses
  input wire logic vehicle_speed_pulse_in, // speedometer pulses
  input wire logic coil_overcurrent_in, // coil current above limit, high
  input wire logic indicator_overcurrent_in, // indicator current above limit
  input wire sig_pkg::sig_avs_req_t avs_req_in, // avalon-mm request
  output sig_pkg::sig_avs_rsp_t avs_rsp_out, // avalon-mm answer
  output logic coil_drive_out, // coil output on, high
  output logic indicator_out // indicator output on, high
);

  // cleaned pin levels
  logic power_lvl;
  logic interlock_n_lvl;
  logic program_n_lvl;
  logic setpoint_n_lvl;
  logic mph_n_lvl;
  logic eng_pulse_lvl;
  logic veh_pulse_lvl;
  logic coil_oc_lvl;
  logic ind_oc_lvl;

  // debounced switch inputs
  sig_input_cond #(.DEB_CYC(DEB_CYC), .RST_LEVEL(1'b0)) u_power (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .raw_in(activation_power_in),
    .level_out(power_lvl)
  );

  // starts closed so nothing engages before the open pin is seen
  sig_input_cond #(.DEB_CYC(DEB_CYC), .RST_LEVEL(1'b0)) u_interlock (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .raw_in(safety_interlock_n_in),
    .level_out(interlock_n_lvl)
  );

  sig_input_cond #(.DEB_CYC(DEB_CYC), .RST_LEVEL(1'b1)) u_program (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .raw_in(program_mode_n_in),
    .level_out(program_n_lvl)
  );

  sig_input_cond #(.DEB_CYC(DEB_CYC), .RST_LEVEL(1'b1)) u_setpoint (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .raw_in(setpoint_latch_select_n_in),
    .level_out(setpoint_n_lvl)
  );

  sig_input_cond #(.DEB_CYC(DEB_CYC), .RST_LEVEL(1'b1)) u_mph_sel (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .raw_in(speed_source_mph_n_in),
    .level_out(mph_n_lvl)
  );

  // fast inputs pass the sync chain only
  sig_input_cond #(.DEB_CYC(sig_pkg::SYNC_ONLY_CYC), .RST_LEVEL(1'b0)) u_eng_pulse (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .raw_in(engine_speed_pulse_in),
    .level_out(eng_pulse_lvl)
  );

  sig_input_cond #(.DEB_CYC(sig_pkg::SYNC_ONLY_CYC), .RST_LEVEL(1'b0)) u_veh_pulse (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .raw_in(vehicle_speed_pulse_in),
    .level_out(veh_pulse_lvl)
  );

  sig_input_cond #(.DEB_CYC(sig_pkg::SYNC_ONLY_CYC), .RST_LEVEL(1'b0)) u_coil_oc (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .raw_in(coil_overcurrent_in),
    .level_out(coil_oc_lvl)
  );

  sig_input_cond #(.DEB_CYC(sig_pkg::SYNC_ONLY_CYC), .RST_LEVEL(1'b0)) u_ind_oc (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .raw_in(indicator_overcurrent_in),
    .level_out(ind_oc_lvl)
  );

  // whole state of the guard, registered in one place
  sig_pkg::sig_top_state_t st_ff;
  sig_pkg::sig_top_state_t nxt_st;

  // decoded conditions and bus helpers
  logic mph_sel;
  logic latch_sel;
  logic prog_req;
  logic interlock_on;
  logic pulse_sel;
  logic pulse_rise;
  logic sp_tap;
  logic gate_end;
  logic overspeed;
  logic engage_ok;
  logic bus_req;
  logic bus_take;
  logic [31:0] rd_word;

  // decoded conditions from the cleaned inputs
  always_comb begin
    mph_sel = ~mph_n_lvl;
    prog_req = ~program_n_lvl;
    latch_sel = ~setpoint_n_lvl & ~prog_req;
    interlock_on = ~interlock_n_lvl;
    pulse_sel = mph_sel ? veh_pulse_lvl : eng_pulse_lvl;
    // edges compare against last cycle's level
    pulse_rise = pulse_sel & ~st_ff.pulse_prev;
    sp_tap = st_ff.sp_prev & ~setpoint_n_lvl;
    gate_end = (st_ff.gate_cnt >= sig_pkg::GATE_CNT_W'(GATE_CYC - 1));
    overspeed = (st_ff.speed > st_ff.disengage);
    // rpm needs below engage, mph needs below the disengage point
    engage_ok = mph_sel ? (st_ff.speed < st_ff.disengage)
                        : (st_ff.speed < st_ff.engage);
    bus_req = avs_req_in.read | avs_req_in.write;
    bus_take = bus_req & ~st_ff.rsp.waitrequest;
  end

  // read data multiplexer, unmapped offsets read zero
  always_comb begin
    rd_word = 32'h0000_0000;
    case (avs_req_in.address)
      sig_pkg::REG_CTRL: begin
        rd_word[sig_pkg::CTRL_INHIBIT_BIT] = st_ff.inhibit;
      end
      sig_pkg::REG_STATUS: begin
        rd_word[sig_pkg::STAT_COIL_BIT] = st_ff.coil;
        rd_word[sig_pkg::STAT_IND_BIT] = st_ff.ind;
        rd_word[sig_pkg::STAT_MODE_LSB +: 3] = st_ff.mode;
        rd_word[sig_pkg::STAT_IND_FAULT_BIT] = st_ff.ind_fault;
        rd_word[sig_pkg::STAT_LATCH_SEL_BIT] = latch_sel;
        rd_word[sig_pkg::STAT_MPH_SEL_BIT] = mph_sel;
        rd_word[sig_pkg::STAT_OVERSPEED_BIT] = overspeed;
      end
      sig_pkg::REG_SPEED: begin
        rd_word[sig_pkg::SPEED_W-1:0] = st_ff.speed;
      end
      sig_pkg::REG_SETPOINT: begin
        rd_word[sig_pkg::SETP_ENGAGE_LSB +: sig_pkg::SPEED_W] = st_ff.engage;
        rd_word[sig_pkg::SETP_DISENGAGE_LSB +: sig_pkg::SPEED_W] = st_ff.disengage;
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase
  end

  // next state of the whole block
  always_comb begin
    nxt_st = st_ff;
    nxt_st.pulse_prev = pulse_sel;
    nxt_st.sp_prev = setpoint_n_lvl;

    // pulse counting over a fixed gate gives the measured speed
    if (gate_end) begin
      nxt_st.gate_cnt = '0;
      nxt_st.speed = st_ff.pulse_cnt;
      // a rise on the closing cycle opens the next window
      nxt_st.pulse_cnt = pulse_rise ? sig_pkg::SPEED_W'(1) : '0;
    end else begin
      nxt_st.gate_cnt = st_ff.gate_cnt + sig_pkg::GATE_CNT_W'(1);
      if (pulse_rise && (st_ff.pulse_cnt != '1)) begin
        nxt_st.pulse_cnt = st_ff.pulse_cnt + sig_pkg::SPEED_W'(1);
      end
    end

    // setpoint taps in program mode alternate engage then disengage
    if (prog_req) begin
      if (sp_tap) begin
        if (!st_ff.sp_idx) begin
          nxt_st.engage = st_ff.speed;
        end else begin
          nxt_st.disengage = st_ff.speed;
        end
        nxt_st.sp_idx = ~st_ff.sp_idx;
      end
    end else begin
      nxt_st.sp_idx = 1'b0;
    end

    // operating state machine
    if (prog_req) begin
      nxt_st.mode = sig_pkg::ST_PROGRAM;
    end else if (!power_lvl) begin
      nxt_st.mode = sig_pkg::ST_OFF;
    end else begin
      case (st_ff.mode)
        // power just arrived, look at the conditions next cycle
        sig_pkg::ST_OFF: begin
          nxt_st.mode = sig_pkg::ST_WAIT;
        end
        // leaving program mode always restarts from off
        sig_pkg::ST_PROGRAM: begin
          nxt_st.mode = sig_pkg::ST_OFF;
        end
        // coil off until no fault, no interlock and speed low enough
        sig_pkg::ST_WAIT: begin
          if (coil_oc_lvl) begin
            nxt_st.mode = sig_pkg::ST_OVERCURRENT;
          end else if (interlock_on) begin
            nxt_st.mode = sig_pkg::ST_INTERLOCK;
          end else if (engage_ok) begin
            nxt_st.mode = sig_pkg::ST_ON;
          end
        end
        // running: faults first, then the speed limit
        sig_pkg::ST_ON: begin
          if (coil_oc_lvl) begin
            nxt_st.mode = sig_pkg::ST_OVERCURRENT;
          end else if (interlock_on) begin
            nxt_st.mode = sig_pkg::ST_INTERLOCK;
          end else if (overspeed) begin
            if (mph_sel || latch_sel) begin
              nxt_st.mode = sig_pkg::ST_LOCKED;
            end else begin
              nxt_st.mode = sig_pkg::ST_WAIT;
            end
          end
        end
        // a released interlock goes back to the engage check
        sig_pkg::ST_INTERLOCK: begin
          if (!interlock_on) begin
            nxt_st.mode = sig_pkg::ST_WAIT;
          end
        end
        // only a power cycle or program mode, both handled above, leaves the lock
        sig_pkg::ST_LOCKED: begin
          nxt_st.mode = sig_pkg::ST_LOCKED;
        end
        // the trip holds, the load stays dead until power is cycled or program mode is entered
        sig_pkg::ST_OVERCURRENT: begin
          nxt_st.mode = sig_pkg::ST_OVERCURRENT;
        end
        default: begin
          nxt_st.mode = sig_pkg::ST_OFF;
        end
      endcase
    end

    // indicator fault holds until activation power drops, new fault wins
    if (ind_oc_lvl) begin
      nxt_st.ind_fault = 1'b1;
    end else if (!power_lvl) begin
      nxt_st.ind_fault = 1'b0;
    end

    // outputs follow the next state so they sit straight on flops
    // the conditioned overcurrent level cuts the coil in the same cycle the state moves
    nxt_st.coil = (nxt_st.mode == sig_pkg::ST_ON) & ~st_ff.inhibit
                  & ~coil_oc_lvl & power_lvl;
    nxt_st.ind = ((nxt_st.mode == sig_pkg::ST_LOCKED)
                 | (nxt_st.mode == sig_pkg::ST_INTERLOCK)
                 | (nxt_st.mode == sig_pkg::ST_OVERCURRENT)
                 | (nxt_st.mode == sig_pkg::ST_WAIT))
                 & ~nxt_st.ind_fault & ~ind_oc_lvl;

    // avalon slave: one wait cycle, then the answer
    nxt_st.rsp.waitrequest = ~(bus_req & st_ff.rsp.waitrequest);
    // read data is captured on the first request cycle
    if (avs_req_in.read && st_ff.rsp.waitrequest) begin
      nxt_st.rsp.readdata = rd_word;
    end
    // a write lands on the cycle that shows waitrequest low
    if (bus_take && avs_req_in.write && (avs_req_in.address == sig_pkg::REG_CTRL)) begin
      nxt_st.inhibit = avs_req_in.writedata[sig_pkg::CTRL_INHIBIT_BIT];
    end
  end

  // state register
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_ff <= '{
        mode: sig_pkg::ST_OFF,
        coil: 1'b0,
        ind: 1'b0,
        ind_fault: 1'b0,
        inhibit: sig_pkg::CTRL_INHIBIT_RST,
        sp_idx: 1'b0,
        sp_prev: 1'b1,
        pulse_prev: 1'b0,
        pulse_cnt: '0,
        gate_cnt: '0,
        speed: '0,
        engage: sig_pkg::ENGAGE_RST,
        disengage: sig_pkg::DISENGAGE_RST,
        rsp: '{waitrequest: 1'b1, readdata: 32'h0000_0000}
      };
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ports driven by state flops
  assign coil_drive_out = st_ff.coil;
  assign indicator_out = st_ff.ind;
  assign avs_rsp_out = st_ff.rsp;

endmodule : sig_top
`default_nettype wire

//--- verification/sig_field_model.sv
// sensor and load model at the far side of the guard
`timescale 1ns/1ns
`default_nettype none

module sig_field_model (
  input wire logic clk_in, // clock
  input wire logic mph_sel_in, // vehicle source wired
  input wire logic [7:0] half_in, // half period, 0 stops
  input wire logic coil_in, // coil drive
  input wire logic ind_in, // indicator drive
  input wire logic coil_short_in, // coil load shorted
  input wire logic ind_short_in, // lamp shorted
  output logic eng_pulse_out, // tach line
  output logic veh_pulse_out, // speedo line
  output logic coil_oc_out, // coil over limit
  output logic ind_oc_out // lamp over limit
);
  logic [7:0] cnt_ff;
  logic wave_ff;
  // square wave sensor, at rest when stopped
  always_ff @(posedge clk_in) begin
    if (half_in == 8'h0) begin
      cnt_ff <= 8'h0;
      wave_ff <= 1'b0;
    end else if (cnt_ff + 8'h1 >= half_in) begin
      cnt_ff <= 8'h0;
      wave_ff <= !wave_ff;
    end else begin
      cnt_ff <= cnt_ff + 8'h1;
    end
  end
  // only the chosen sensor is wired, the other input is pulled down
  assign eng_pulse_out = mph_sel_in ? 1'b0 : wave_ff;
  assign veh_pulse_out = mph_sel_in ? wave_ff : 1'b0;
  // a shorted load draws current only through the guard's own drive
  assign coil_oc_out = coil_in & coil_short_in;
  assign ind_oc_out = ind_in & ind_short_in;
endmodule : sig_field_model
`default_nettype wire

//--- verification/sig_top_asserts.sv
// port checker for the guard top
`timescale 1ns/1ns
`default_nettype none

module sig_top_asserts (
  input wire logic clk_in, // clock
  input wire logic rst_in, // reset
  input wire logic activation_power_in, // power
  input wire logic safety_interlock_n_in, // interlock
  input wire logic program_mode_n_in, // program
  input wire logic coil_overcurrent_in, // coil oc
  input wire logic indicator_overcurrent_in, // ind oc
  input wire sig_pkg::sig_avs_req_t avs_req_in, // request
  input wire sig_pkg::sig_avs_rsp_t avs_rsp_out, // answer
  input wire logic coil_drive_out, // coil
  input wire logic indicator_out // indicator
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  // any bus request
  wire logic req = avs_req_in.read | avs_req_in.write;
  wire logic wr = avs_rsp_out.waitrequest;

  a_bus_one_wait: assert property (req && wr |=> !wr)
    else $error("bus answer late");
  a_wait_stands_one: assert property (!wr |=> wr)
    else $error("waitrequest low too long");
  a_unmapped_reads_zero: assert property (avs_req_in.read && wr &&
      avs_req_in.address[1:0] != 2'h0 |=> avs_rsp_out.readdata == 32'h0)
    else $error("unmapped read not zero");
  a_reset_outputs_quiet: assert property ($fell(rst_in) |-> !coil_drive_out && !indicator_out && wr)
    else $error("outputs active after reset");
  a_power_drops_coil: assert property (!activation_power_in [*8] ##1 !activation_power_in [*8]
      |-> !coil_drive_out)
    else $error("coil on without power");
  a_interlock_drops_coil: assert property (!safety_interlock_n_in [*8] ##1
      !safety_interlock_n_in [*8] |-> !coil_drive_out)
    else $error("coil on with interlock closed");
  a_program_drops_coil: assert property (!program_mode_n_in [*8] ##1
      !program_mode_n_in [*8] |-> !coil_drive_out)
    else $error("coil on in program mode");
  a_coil_oc_off: assert property ($rose(coil_overcurrent_in) |-> ##[1:6] !coil_drive_out)
    else $error("coil not cut on overcurrent");
  a_ind_oc_off: assert property ($rose(indicator_overcurrent_in) |-> ##[1:6] !indicator_out)
    else $error("indicator not cut on overcurrent");

  // main scenarios
  c_coil_on: cover property ($rose(coil_drive_out));
  c_read_done: cover property (avs_req_in.read && !wr);
  c_oc_seen: cover property ($rose(coil_overcurrent_in));
endmodule : sig_top_asserts

bind sig_top sig_top_asserts sig_top_asserts_inst (
  .clk_in(clk_in), .rst_in(rst_in), .activation_power_in(activation_power_in),
  .safety_interlock_n_in(safety_interlock_n_in), .program_mode_n_in(program_mode_n_in),
  .coil_overcurrent_in(coil_overcurrent_in),
  .indicator_overcurrent_in(indicator_overcurrent_in), .avs_req_in(avs_req_in),
  .avs_rsp_out(avs_rsp_out), .coil_drive_out(coil_drive_out), .indicator_out(indicator_out)
);
`default_nettype wire

//--- verification/tb_top.sv
// self-checking bench for the guard top
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  localparam int unsigned GATE = 256;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic pwr = 1'b0;
  logic lock_n = 1'b1;
  logic prog_n = 1'b1;
  logic sp_n = 1'b1;
  logic mph_n = 1'b1;
  logic c_short = 1'b0;
  logic i_short = 1'b0;
  logic [7:0] half = 8'h0;
  logic eng, veh, c_oc, i_oc, coil, ind;
  sig_pkg::sig_avs_req_t req = '0;
  sig_pkg::sig_avs_rsp_t rsp;
  int n_fail = 0;
  int checks_done = 0;
  logic [31:0] rd;
  logic [7:0] h;

  // clock
  initial begin
    forever #5 clk_in = !clk_in;
  end

  sig_top #(.DEB_CYC(4), .GATE_CYC(GATE)) sig_top_inst (
    .clk_in(clk_in), .rst_in(rst_in), .activation_power_in(pwr),
    .safety_interlock_n_in(lock_n), .program_mode_n_in(prog_n),
    .setpoint_latch_select_n_in(sp_n), .speed_source_mph_n_in(mph_n),
    .engine_speed_pulse_in(eng), .vehicle_speed_pulse_in(veh),
    .coil_overcurrent_in(c_oc), .indicator_overcurrent_in(i_oc),
    .avs_req_in(req), .avs_rsp_out(rsp), .coil_drive_out(coil), .indicator_out(ind)
  );
  sig_field_model sig_field_model_inst (
    .clk_in(clk_in), .mph_sel_in(!mph_n), .half_in(half), .coil_in(coil), .ind_in(ind),
    .coil_short_in(c_short), .ind_short_in(i_short), .eng_pulse_out(eng),
    .veh_pulse_out(veh), .coil_oc_out(c_oc), .ind_oc_out(i_oc)
  );

  // pulses per gate for a given half period
  function automatic logic [31:0] exp_speed(input logic [7:0] hp);
    return 32'(GATE / (2 * hp));
  endfunction : exp_speed

  function automatic logic [7:0] slow();
    return 8'(16 + $urandom % 15);
  endfunction : slow

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input int tol);
    checks_done++;
    if ((got + tol >= exp && got <= exp + tol) !== 1'b1) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic ride(input int n);
    repeat (n) @(posedge clk_in);
  endtask : ride

  // one avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    req.read <= !wr;
    req.write <= wr;
    req.address <= a;
    req.writedata <= d;
    do begin
      @(posedge clk_in);
    end while (rsp.waitrequest !== 1'b0);
    rd = rsp.readdata;
    req.read <= 1'b0;
    req.write <= 1'b0;
    @(posedge clk_in);
  endtask : bus

  task automatic wait_coil(input logic exp);
    int n;
    n = 0;
    while (coil !== exp && n < 3000) begin
      @(posedge clk_in);
      n++;
    end
    chk(coil, exp, 0);
  endtask : wait_coil

  task automatic cycle_power();
    pwr <= 1'b0;
    ride(600);
    pwr <= 1'b1;
  endtask : cycle_power

  task automatic tap();
    sp_n <= 1'b0;
    ride(20);
    sp_n <= 1'b1;
    ride(20);
  endtask : tap

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test

  // watchdog
  initial begin
    #900_000;
    n_fail++;
    finish_test();
  end

  // main sequence
  initial begin
    void'($urandom(14396));
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    chk({coil, ind}, 2'h0, 0);
    bus(1'b1, sig_pkg::REG_SETPOINT, 32'hffffffff);
    bus(1'b0, sig_pkg::REG_SETPOINT, 32'h0);
    chk(rd, {sig_pkg::DISENGAGE_RST, sig_pkg::ENGAGE_RST}, 0);
    bus(1'b0, 4'h2, 32'h0);
    chk(rd, 32'h0, 0);
    bus(1'b0, sig_pkg::REG_CTRL, 32'h0);
    chk(rd, 32'h0, 0);
    // mid speed blocks first engage, slow speed allows it
    half <= 8'h5;
    ride(600);
    pwr <= 1'b1;
    ride(1500);
    chk(coil, 1'b0, 0);
    h = slow();
    half <= h;
    wait_coil(1'b1);
    ride(600);
    bus(1'b0, sig_pkg::REG_SPEED, 32'h0);
    chk(rd, exp_speed(h), 2);
    // standard mode overspeed and automatic return
    half <= 8'h3;
    wait_coil(1'b0);
    bus(1'b0, sig_pkg::REG_STATUS, 32'h0);
    chk(rd[8], 1'b1, 0);
    half <= slow();
    wait_coil(1'b1);
    // software inhibit
    bus(1'b1, sig_pkg::REG_CTRL, 32'h1);
    ride(2);
    chk(coil, 1'b0, 0);
    bus(1'b1, sig_pkg::REG_CTRL, 32'h0);
    wait_coil(1'b1);
    // latched rpm mode
    sp_n <= 1'b0;
    ride(20);
    half <= 8'h3;
    wait_coil(1'b0);
    bus(1'b0, sig_pkg::REG_STATUS, 32'h0);
    chk(rd[4:2], 3'(sig_pkg::ST_LOCKED), 0);
    half <= slow();
    ride(1500);
    chk(coil, 1'b0, 0);
    half <= 8'h3;
    cycle_power();
    ride(1500);
    chk(coil, 1'b0, 0);
    half <= slow();
    wait_coil(1'b1);
    sp_n <= 1'b1;
    // vehicle speed mode, always latched
    pwr <= 1'b0;
    mph_n <= 1'b0;
    half <= 8'h5;
    ride(40);
    pwr <= 1'b1;
    wait_coil(1'b1);
    half <= 8'h3;
    wait_coil(1'b0);
    half <= slow();
    ride(1500);
    chk(coil, 1'b0, 0);
    half <= 8'h3;
    cycle_power();
    ride(1500);
    chk(coil, 1'b0, 0);
    half <= 8'h5;
    wait_coil(1'b1);
    pwr <= 1'b0;
    mph_n <= 1'b1;
    half <= slow();
    ride(40);
    pwr <= 1'b1;
    wait_coil(1'b1);
    // interlock, with a lamp short meanwhile
    lock_n <= 1'b0;
    wait_coil(1'b0);
    ride(20);
    chk(ind, 1'b1, 0);
    i_short <= 1'b1;
    ride(20);
    chk(ind, 1'b0, 0);
    i_short <= 1'b0;
    half <= 8'h3;
    ride(600);
    lock_n <= 1'b1;
    ride(1500);
    chk(coil, 1'b0, 0);
    half <= slow();
    wait_coil(1'b1);
    // coil overcurrent holds until a power cycle
    c_short <= 1'b1;
    wait_coil(1'b0);
    c_short <= 1'b0;
    ride(300);
    chk(coil, 1'b0, 0);
    cycle_power();
    wait_coil(1'b1);
    // program mode captures engage then disengage
    prog_n <= 1'b0;
    wait_coil(1'b0);
    h = 8'(8 + $urandom % 5);
    half <= h;
    ride(600);
    tap();
    half <= 8'h4;
    ride(600);
    tap();
    prog_n <= 1'b1;
    bus(1'b0, sig_pkg::REG_SETPOINT, 32'h0);
    chk(rd[15:0], exp_speed(h), 2);
    chk(rd[31:16], exp_speed(8'h4), 2);
    half <= slow();
    wait_coil(1'b1);
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
